// [wsq_pkg.sv]
// Purpose : Shared constants, opcodes and helpers of the waveform sequencer
// Assumes : One system clock serves as sample clock; sequencer tick is derived
// Notes   : Lengths are in sample cycles, pause counts in sequencer ticks
package wsq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 100_000_000;     // mclk rate
    localparam int unsigned TICK_DIV      = 8;               // Sequencer clock = sample clock / 8
    localparam int unsigned TICK_W        = $clog2(TICK_DIV);
    localparam int unsigned GRAIN         = 16;              // Waveform granularity in samples
    localparam int unsigned GAP_MIN       = 32;              // Shortest zero gap or hold
    localparam int unsigned PHASE_SETTLE  = 30;              // Advised pause after phase setup

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned ARG_W         = 32;
    localparam int unsigned ADR_W         = 16;
    localparam int unsigned SMP_W         = 16;
    localparam int unsigned MRK_W         = 2;
    localparam int unsigned PHASE_W       = 16;
    localparam logic [SMP_W-1:0]   SMP_RST   = 16'h0000;
    localparam logic [MRK_W-1:0]   MRK_RST   = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        emit_waveform_cmd,
        emit_zero_gap_cmd,
        hold_last_sample_cmd,
        playback_end_barrier,
        pause_cmd,
        trigger_level_cmd,
        oscillator_phase_clear,
        sine_phase_offset_cmd
    } wsq_op_t;

    // Length legal for its playback kind
    function automatic logic wsq_len_ok(input wsq_op_t op, input logic [ARG_W-1:0] len);
        logic ok;
        ok = (len[3:0] == 4'h0) && (len != '0);
        if (op != emit_waveform_cmd) begin
            ok = ok && (len >= ARG_W'(GAP_MIN));
        end
        return ok;
    endfunction : wsq_len_ok

    // True for entries of the playback queue
    function automatic logic wsq_is_play(input wsq_op_t op);
        return (op == emit_waveform_cmd) || (op == emit_zero_gap_cmd) || (op == hold_last_sample_cmd);
    endfunction : wsq_is_play

endpackage : wsq_pkg

// [wsq_pb_if.sv]
// Purpose : Carries playback queue entries from dispatcher to playback engine
// Assumes : Single clock domain
// Notes   : Push is taken when push_valid and push_ready are both high
`timescale 1ns/10ps
interface wsq_pb_if;
    logic                           push_valid;
    logic                           push_ready;
    wsq_pkg::wsq_op_t               push_kind;
    logic [wsq_pkg::ARG_W-1:0]      push_len;
    logic [wsq_pkg::ADR_W-1:0]      push_addr;
    logic                           busy;

    modport disp (output push_valid, push_kind, push_len, push_addr, input push_ready, busy);
    modport play (input push_valid, push_kind, push_len, push_addr, output push_ready, busy);
endinterface : wsq_pb_if

// [wsq_playback.sv]
// Purpose : Playback queue engine: waveforms, zero gaps, holds, back to back
// Assumes : Dispatcher only pushes legal lengths
// Notes   : One pending slot lets the next entry start without a gap
`timescale 1ns/10ps
module wsq_playback #(
    parameter int unsigned MEM_AW = 10
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // Queue side
    wsq_pb_if.play                           pb,
    // Waveform memory load
    input  wire logic                        wmem_we,
    input  wire logic [MEM_AW-1:0]           wmem_addr,
    input  wire logic [wsq_pkg::SMP_W*2+wsq_pkg::MRK_W-1:0] wmem_data,
    // Sample outputs
    output logic      [wsq_pkg::SMP_W-1:0]   out_i,
    output logic      [wsq_pkg::SMP_W-1:0]   out_q,
    output logic      [wsq_pkg::MRK_W-1:0]   out_mrk
);
    localparam int unsigned WW = wsq_pkg::SMP_W*2 + wsq_pkg::MRK_W;

    // Memory words are {marker, Q, I}
    logic [WW-1:0] wmem [2**MEM_AW];

    logic                         act_q, act_d, pend_q, pend_d;
    wsq_pkg::wsq_op_t             kind_q, kind_d, pkind_q, pkind_d;
    logic [wsq_pkg::ARG_W-1:0]    cnt_q, cnt_d, plen_q, plen_d;
    logic [MEM_AW-1:0]            rd_q, rd_d, padr_q, padr_d;
    logic [WW-1:0]                smp_q, smp_d;
    logic                         load;

    // ------------------------------------------------------------------
    // Waveform memory write
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (wmem_we) begin
            wmem[wmem_addr] <= wmem_data;
        end
    end

    assign pb.push_ready = !pend_q;
    assign pb.busy       = act_q || pend_q;
    assign out_i         = smp_q[wsq_pkg::SMP_W-1:0];
    assign out_q         = smp_q[wsq_pkg::SMP_W*2-1:wsq_pkg::SMP_W];
    assign out_mrk       = smp_q[WW-1:wsq_pkg::SMP_W*2];

    // ------------------------------------------------------------------
    // Next state: load on the last sample so entries run gapless
    // ------------------------------------------------------------------
    always_comb begin
        act_d  = act_q;
        kind_d = kind_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        pend_d = pend_q;
        pkind_d = pkind_q;
        plen_d = plen_q;
        padr_d = padr_q;
        smp_d  = '0;                                    // Idle outputs are zero
        load   = pend_q && (!act_q || cnt_q == 1);      // No idle sample between entries
        if (act_q) begin
            case (kind_q)
                wsq_pkg::emit_waveform_cmd: smp_d = wmem[rd_q];
                wsq_pkg::emit_zero_gap_cmd: smp_d = '0;
                wsq_pkg::hold_last_sample_cmd: smp_d = smp_q;  // No memory read
                default: smp_d = '0;
            endcase
            cnt_d = cnt_q - 1;
            rd_d  = rd_q + 1'b1;
            if (cnt_q == 1) begin
                act_d = 1'b0;
            end
        end
        if (load) begin
            act_d  = 1'b1;
            kind_d = pkind_q;
            cnt_d  = plen_q;
            rd_d   = padr_q;
            pend_d = 1'b0;
        end
        if (pb.push_valid && !pend_q) begin
            pend_d  = 1'b1;
            pkind_d = pb.push_kind;
            plen_d  = pb.push_len;
            padr_d  = pb.push_addr[MEM_AW-1:0];
        end
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            act_q <= 1'b0;
            pend_q <= 1'b0;
            kind_q <= wsq_pkg::emit_zero_gap_cmd;
            pkind_q <= wsq_pkg::emit_zero_gap_cmd;
            cnt_q <= '0;
            plen_q <= '0;
            rd_q <= '0;
            padr_q <= '0;
            smp_q <= '0;
        end else begin
            act_q <= act_d;
            pend_q <= pend_d;
            kind_q <= kind_d;
            pkind_q <= pkind_d;
            cnt_q <= cnt_d;
            plen_q <= plen_d;
            rd_q <= rd_d;
            padr_q <= padr_d;
            smp_q <= smp_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_zero_gap_out: assert property (act_q && kind_q == wsq_pkg::emit_zero_gap_cmd |=> smp_q == '0)
        else $error("zero gap emitted nonzero sample");
    a_gapless_next: assert property (act_q && cnt_q == 1 && pend_q |=> act_q && !pend_q)
        else $error("gap inserted between playback entries");
    a_hold_keeps: assert property (act_q && kind_q == wsq_pkg::hold_last_sample_cmd |=> $stable(smp_q))
        else $error("hold changed the output");
    a_idle_zero: assert property (!act_q |=> smp_q == '0)
        else $error("idle output not zero");
endmodule : wsq_playback

// [wsq_sequencer.sv]
// Purpose : Instruction sequencer splitting commands into playback and wait-and-set queues
// Assumes : mclk is the sample clock; commands arrive on a valid/ready stream
// Notes   : Illegal playback lengths are dropped and reported on cmd_err
`timescale 1ns/10ps
module wsq_sequencer #(
    parameter int unsigned MEM_AW = 10,
    parameter int unsigned TRIG_N = 4
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // Command stream
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire logic [2:0]                  cmd_op,
    input  wire logic [wsq_pkg::ARG_W-1:0]   cmd_arg,
    input  wire logic [wsq_pkg::ADR_W-1:0]   cmd_addr,
    output logic                             cmd_err,
    // Waveform memory load
    input  wire logic                        wmem_we,
    input  wire logic [MEM_AW-1:0]           wmem_addr,
    input  wire logic [wsq_pkg::SMP_W*2+wsq_pkg::MRK_W-1:0] wmem_data,
    // Sample outputs
    output logic      [wsq_pkg::SMP_W-1:0]   out_i,
    output logic      [wsq_pkg::SMP_W-1:0]   out_q,
    output logic      [wsq_pkg::MRK_W-1:0]   out_mrk,
    // Trigger and oscillator controls
    output logic      [TRIG_N-1:0]           trig_out,
    output logic                             osc_phase_clr,
    output logic      [wsq_pkg::PHASE_W-1:0] sine_phase,
    // Sequencer tick
    output logic                             seq_tick
);
    typedef enum logic [1:0] {WSQ_RUN, WSQ_PAUSE, WSQ_BARRIER} wsq_state_t;

    wsq_pb_if pb ();

    wsq_state_t                   st_q, st_d;
    logic [wsq_pkg::TICK_W-1:0]   div_q, div_d;
    logic [wsq_pkg::ARG_W-1:0]    pcnt_q, pcnt_d;
    logic [TRIG_N-1:0]            trig_q, trig_d;
    logic [wsq_pkg::PHASE_W-1:0]  ph_q, ph_d;
    logic                         clr_q, clr_d, err_q, err_d;
    wsq_pkg::wsq_op_t             op;
    logic                         is_play, take;

    // ------------------------------------------------------------------
    // Playback engine
    // ------------------------------------------------------------------
    wsq_playback #(.MEM_AW(MEM_AW)) u_play (
        .mclk      (mclk),
        .rstn      (rstn),
        .pb        (pb.play),
        .wmem_we   (wmem_we),
        .wmem_addr (wmem_addr),
        .wmem_data (wmem_data),
        .out_i     (out_i),
        .out_q     (out_q),
        .out_mrk   (out_mrk)
    );

    assign op       = wsq_pkg::wsq_op_t'(cmd_op);
    assign is_play  = wsq_pkg::wsq_is_play(op);
    assign seq_tick = (div_q == '0);                              // One tick per eight samples
    // Ready stays combinational so a slot that frees on the last sample is refilled at once;
    // registering it would open a one-sample hole between back-to-back entries
    // Wait-and-set commands never wait for playback unless a barrier is active
    assign cmd_ready = (st_q == WSQ_RUN) && (!is_play || pb.push_ready);
    assign take     = cmd_valid && cmd_ready;
    assign pb.push_valid = take && is_play && wsq_pkg::wsq_len_ok(op, cmd_arg);
    assign pb.push_kind  = op;
    assign pb.push_len   = cmd_arg;
    assign pb.push_addr  = cmd_addr;
    assign trig_out      = trig_q;
    assign osc_phase_clr = clr_q;
    assign sine_phase    = ph_q;
    assign cmd_err       = err_q;

    // ------------------------------------------------------------------
    // Dispatcher and wait-and-set queue
    // ------------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        div_d  = (div_q == wsq_pkg::TICK_W'(wsq_pkg::TICK_DIV - 1)) ? '0 : div_q + 1'b1;
        pcnt_d = pcnt_q;
        trig_d = trig_q;
        ph_d   = ph_q;
        clr_d  = 1'b0;
        // Bad lengths are taken and dropped so a wrong command cannot stall the stream
        err_d  = take && is_play && !wsq_pkg::wsq_len_ok(op, cmd_arg);
        case (st_q)
            WSQ_RUN: begin
                if (take) begin
                    case (op)
                        wsq_pkg::playback_end_barrier: st_d = WSQ_BARRIER;
                        wsq_pkg::pause_cmd: begin
                            // Count is in whole sequencer ticks
                            if (cmd_arg != '0) begin
                                st_d   = WSQ_PAUSE;
                                pcnt_d = cmd_arg;
                            end
                        end
                        wsq_pkg::trigger_level_cmd: trig_d = cmd_arg[TRIG_N-1:0];
                        wsq_pkg::oscillator_phase_clear: clr_d = 1'b1;
                        wsq_pkg::sine_phase_offset_cmd: ph_d = cmd_arg[wsq_pkg::PHASE_W-1:0];
                        default: st_d = WSQ_RUN;
                    endcase
                end
            end
            WSQ_PAUSE: begin
                // Execution resumes after n ticks
                if (seq_tick) begin
                    pcnt_d = pcnt_q - 1;
                    if (pcnt_q == 1) begin
                        st_d = WSQ_RUN;
                    end
                end
            end
            WSQ_BARRIER: begin
                // Engine and slot must both be empty, else a queued entry would be overtaken
                if (!pb.busy) begin
                    st_d = WSQ_RUN;
                end
            end
            default: st_d = WSQ_RUN;
        endcase
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_q   <= WSQ_RUN;
            div_q  <= '0;
            pcnt_q <= '0;
            trig_q <= '0;
            ph_q   <= wsq_pkg::PHASE_RST;
            clr_q  <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            pcnt_q <= pcnt_d;
            trig_q <= trig_d;
            ph_q   <= ph_d;
            clr_q  <= clr_d;
            err_q  <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_tick_period: assert property (seq_tick |=> !seq_tick [*7] ##1 seq_tick)
        else $error("sequencer tick not one in eight");
    a_pause_steady: assert property (st_q == WSQ_PAUSE && !seq_tick |=> $stable(pcnt_q) && st_q == WSQ_PAUSE)
        else $error("pause count moved without a tick");
    a_pause_blocks: assert property (st_q == WSQ_PAUSE |-> !cmd_ready)
        else $error("command taken during pause");
    a_pause_end: assert property (st_q == WSQ_PAUSE && seq_tick && pcnt_q == 1 |=> st_q == WSQ_RUN)
        else $error("pause did not end on its last tick");
    a_barrier_hold: assert property (st_q == WSQ_BARRIER && pb.busy |=> st_q == WSQ_BARRIER && !cmd_ready)
        else $error("barrier released while playback busy");
    a_ws_parallel: assert property (st_q == WSQ_RUN && !is_play |-> cmd_ready)
        else $error("wait-and-set command stalled by playback");
    a_trig_set: assert property (take && op == wsq_pkg::trigger_level_cmd
        |=> trig_out == $past(cmd_arg[TRIG_N-1:0])) else $error("trigger level not applied");
    a_trig_keep: assert property (!(take && op == wsq_pkg::trigger_level_cmd) |=> $stable(trig_out))
        else $error("trigger level changed without command");
    a_len_reject: assert property (take && is_play && cmd_arg[3:0] != 4'h0 |=> cmd_err)
        else $error("bad playback length not flagged");

    // Playback screening: only lengths on the 16-sample grain reach the queue
    a_push_grain: assert property (pb.push_valid |-> cmd_arg[3:0] == 4'h0 && cmd_arg != '0)
        else $error("off-grain length pushed to playback");
    a_good_quiet: assert property (pb.push_valid |=> !cmd_err)
        else $error("legal length flagged as error");
    a_short_gap: assert property (take && is_play && op != wsq_pkg::emit_waveform_cmd
        && cmd_arg < wsq_pkg::GAP_MIN |=> cmd_err)
        else $error("short gap or hold not flagged");
    a_zero_queued: assert property (take && op == wsq_pkg::emit_zero_gap_cmd && cmd_arg[3:0] == 4'h0
        && cmd_arg >= wsq_pkg::GAP_MIN |-> pb.push_valid)
        else $error("legal zero gap not queued for playback");

    // Barrier entry and release
    a_barrier_enter: assert property (take && op == wsq_pkg::playback_end_barrier |=> st_q == WSQ_BARRIER)
        else $error("barrier not entered");
    a_barrier_release: assert property (st_q == WSQ_BARRIER && !pb.busy |=> st_q == WSQ_RUN)
        else $error("barrier held after playback finished");

    // Pause counting, one step per sequencer tick
    a_pause_load: assert property (take && op == wsq_pkg::pause_cmd && cmd_arg != '0
        |=> st_q == WSQ_PAUSE && pcnt_q == $past(cmd_arg))
        else $error("pause count not loaded");
    a_pause_count: assert property (st_q == WSQ_PAUSE && seq_tick && pcnt_q != 1
        |=> st_q == WSQ_PAUSE && pcnt_q == $past(pcnt_q) - 1)
        else $error("pause count not stepped on tick");
    a_pause_zero: assert property (take && op == wsq_pkg::pause_cmd && cmd_arg == '0 |=> st_q == WSQ_RUN)
        else $error("zero pause stalled the sequencer");

    // Trigger encodings
    a_trig_clear: assert property (take && op == wsq_pkg::trigger_level_cmd && cmd_arg[TRIG_N-1:0] == '0
        |=> trig_out == '0)
        else $error("trigger clear left an output high");
    a_trig_first: assert property (take && op == wsq_pkg::trigger_level_cmd
        && cmd_arg[TRIG_N-1:0] == TRIG_N'(32'h0000_0001) |=> trig_out[0])
        else $error("first trigger output not raised");
endmodule : wsq_sequencer

// [wsq_instr_sink.sv]
// Purpose : Far-side instrument model that logs every sample word
// Assumes : Channel outputs settle before each rising mclk
// Notes   : Passive; an idle channel and a zero gap look the same here
`timescale 1ns/10ps
module wsq_instr_sink (
    // Clock
    input  wire logic        mclk,
    // Log control
    input  wire logic        clear,
    // Observed channel
    input  wire logic [15:0] out_i,
    input  wire logic [15:0] out_q,
    input  wire logic [1:0]  out_mrk
);
    logic [33:0] log_q [0:255];
    int          idx_q = 0;

    // -------------------------------------------------------------
    // Sample log
    // -------------------------------------------------------------
    // One word per sample clock; wraps instead of stopping, so keep runs short
    always @(posedge mclk) begin
        log_q[idx_q[7:0]] <= {out_mrk, out_q, out_i};
        idx_q <= clear ? 0 : idx_q + 1;
    end
endmodule : wsq_instr_sink

// [tb.sv]
// Purpose : Self-checking bench for the waveform sequencer
// Assumes : Commands are offered 1 ns after a rising edge
// Notes   : Sample stream is judged from the instrument model's log
`timescale 1ns/10ps
module tb;
    logic        mclk, rstn, cmd_valid, cmd_ready, cmd_err, wmem_we, clear;
    logic [2:0]  cmd_op;
    logic [31:0] cmd_arg;
    logic [15:0] cmd_addr, out_i, out_q, sine_phase;
    logic [9:0]  wmem_addr;
    logic [33:0] wmem_data;
    logic [1:0]  out_mrk;
    logic [3:0]  trig_out;
    logic        osc_phase_clr, seq_tick;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    wsq_sequencer dut (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_addr(cmd_addr), .cmd_err(cmd_err),
        .wmem_we(wmem_we), .wmem_addr(wmem_addr), .wmem_data(wmem_data), .out_i(out_i),
        .out_q(out_q), .out_mrk(out_mrk), .trig_out(trig_out), .osc_phase_clr(osc_phase_clr),
        .sine_phase(sine_phase), .seq_tick(seq_tick));
    wsq_instr_sink sink (.mclk(mclk), .clear(clear), .out_i(out_i), .out_q(out_q), .out_mrk(out_mrk));

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    // Memory word k; every field nonzero so idle never passes for data
    function automatic logic [33:0] wd(input int k);
        return {2'h1, 16'h0100 + 16'(k), 16'h0200 + 16'(k)};
    endfunction : wd

    task check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    // Valid stays up on return so a following send needs no second assignment
    task send(input logic [2:0] op, input logic [31:0] arg, input logic [15:0] adr);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_arg = arg;
        cmd_addr = adr;
        // Ready is judged at the falling edge, settled for the rising edge that takes; a stuck
        // command is left to the watchdog
        @(negedge mclk);
        while (cmd_ready !== 1'b1) begin
            @(negedge mclk);
        end
        @(posedge mclk);
        #1;
    endtask : send

    task idle;
        cmd_valid = 1'b0;
    endtask : idle

    // Count one-cycle pulses over the three cycles after a take
    task pulses(output int ne, output int nc);
        ne = 0;
        nc = 0;
        repeat (3) begin
            ne += int'(cmd_err === 1'b1);
            nc += int'(osc_phase_clr === 1'b1);
            @(posedge mclk);
            #1;
        end
    endtask : pulses

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task t_tick;
        int n, last, k;
        n = 0;
        last = -1;
        for (k = 0; k < 80; k++) begin
            if (seq_tick === 1'b1) begin
                if (last >= 0) check(k - last, 8);
                last = k;
                n++;
            end
            @(posedge mclk);
            #1;
        end
        check(n, 10);
    endtask : t_tick

    // Wave, zero gap, wave, hold pushed back to back, then idle
    task t_play;
        int b, k;
        logic [33:0] e;
        for (k = 0; k < 32; k++) begin
            wmem_we = 1'b1;
            wmem_addr = 10'(k);
            wmem_data = wd(k);
            @(posedge mclk);
            #1;
        end
        wmem_we = 1'b0;
        clear = 1'b1;
        @(posedge mclk);
        #1;
        clear = 1'b0;
        send(3'h0, 32'h0000_0010, 16'h0000);
        send(3'h1, 32'h0000_0020, 16'h0000);
        send(3'h0, 32'h0000_0010, 16'h0010);
        send(3'h2, 32'h0000_0020, 16'h0000);
        idle();
        repeat (140) @(posedge mclk);
        #1;
        b = -1;
        for (k = 0; k < 40; k++) if (b < 0 && sink.log_q[k] === wd(0)) b = k;
        check(b >= 0, 1);
        for (k = 0; k < 100; k++) begin
            e = k < 16 ? wd(k) : k < 48 ? 34'h0 : k < 64 ? wd(k - 32) : k < 96 ? wd(31) : 34'h0;
            check(sink.log_q[b + k], e);
        end
    endtask : t_play

    // Illegal lengths are taken, dropped and flagged for one cycle
    task t_badlen;
        logic [2:0]  ops [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
        logic [31:0] lens [4] = '{32'h0000_0008, 32'h0000_0000, 32'h0000_0010, 32'h0000_0028};
        int ne, nc, k;
        for (k = 0; k < 4; k++) begin
            send(ops[k], lens[k], 16'h0000);
            idle();
            pulses(ne, nc);
            check(ne, 1);
        end
    endtask : t_badlen

    // Phase setup, settle pause, pause length measured at cmd_ready
    task t_phase;
        int ne, nc, n;
        send(3'h6, 32'h0000_0000, 16'h0000);
        idle();
        pulses(ne, nc);
        check(nc, 1);
        send(3'h7, 32'h0000_1234, 16'h0000);
        send(3'h4, 32'h0000_001e, 16'h0000);
        idle();
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(n >= 232 && n <= 242, 1);
        check(sine_phase, 16'h1234);
    endtask : t_phase

    // Trigger alongside playback, then held back by the barrier
    task t_barrier;
        int t0;
        send(3'h1, 32'h0000_0040, 16'h0000);
        send(3'h5, 32'h0000_0001, 16'h0000);
        idle();
        repeat (2) @(posedge mclk);
        #1;
        check(trig_out, 4'h1);
        send(3'h1, 32'h0000_0040, 16'h0000);
        t0 = cyc;
        send(3'h3, 32'h0000_0000, 16'h0000);
        check(trig_out, 4'h1);
        send(3'h5, 32'h0000_0000, 16'h0000);
        idle();
        repeat (2) @(posedge mclk);
        #1;
        check(trig_out, 4'h0);
        check(cyc - t0 >= 64 && cyc - t0 <= 150, 1);
    endtask : t_barrier

    // -------------------------------------------------------------
    // Clock, watchdog, main sequence
    // -------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Generous ceiling; the whole run needs well under 2000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task summarize;
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_arg = 32'h0000_0000;
        cmd_addr = 16'h0000;
        wmem_we = 1'b0;
        wmem_addr = 10'h000;
        wmem_data = 34'h0;
        clear = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        rstn = 1'b1;
        check(trig_out, 4'h0);
        t_tick();
        t_play();
        t_badlen();
        t_phase();
        t_barrier();
        summarize();
    end
endmodule : tb
